/* pkg/pwr_reset_pkg.sv */
// Constants, state encoding and timing counts for the power-state and reset controller.
// Assumes a single 50 MHz master clock domain; all asynchronous inputs arrive through synchronisers.
package pwr_reset_pkg;

  // Master clock of this block.
  localparam int unsigned MCLK_HZ = 50_000_000;
  localparam int unsigned MCLK_PERIOD_PS = 1_000_000_000 / (MCLK_HZ / 1_000);

  // Control-register value that requests a device reset.
  localparam logic [7:0] CTRL_RESET_KEY = 8'h58;

  // Serial reset patterns: ones before a closing zero, ones before chip select rises.
  localparam logic [10:0] PATTERN_ONES_ZERO_END = 11'h3FF;
  localparam logic [10:0] PATTERN_ONES_CS_END = 11'h400;

  // Converter master clock demanded by each speed mode, in kHz.
  localparam logic [15:0] HS_MCLK_KHZ = 16'h6400;
  localparam logic [15:0] LS_MCLK_KHZ = 16'h0C80;

  // Time from reset release until the serial interface accepts frames.
  localparam int unsigned SERIAL_READY_NS = 200;
  localparam logic [7:0] SERIAL_READY_COUNT =
    8'((SERIAL_READY_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS);

  // Conversion timing in master clock cycles.
  localparam logic [7:0] STANDBY_EXTRA_CYCLES = 8'h18;
  localparam logic [7:0] LATENCY_CYCLES = 8'h40;
  localparam logic [7:0] CONV_PERIOD_CYCLES = 8'h20;
  localparam logic [7:0] DATA_READY_N_LOW_CYCLES = 8'h04;

  // Values after reset of the sticky status flags.
  localparam logic POR_FLAG_RESET = 1'b1;
  localparam logic ANALOG_LOW_VOLTAGE_FLAG_RESET = 1'b1;

  // Positions in the synchroniser vector and its idle value under reset.
  localparam int SYNC_START = 0;
  localparam int SYNC_RESET_PIN = 1;
  localparam int SYNC_IO_OK = 2;
  localparam int SYNC_SDI = 3;
  localparam int SYNC_CS = 4;
  localparam int SYNC_SCLK = 5;
  localparam int SYNC_ANALOG = 6;
  localparam int SYNC_WIDTH = 10;
  localparam logic [SYNC_WIDTH-1:0] SYNC_RESET_VAL = 10'h012;

  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_WAIT_READY = 3'b001,
    ST_STOPPED = 3'b010,
    ST_SETTLE = 3'b011,
    ST_CONVERT = 3'b100,
    ST_POWER_DOWN = 3'b101
  } ctrl_state_t;

endpackage

/* hdl/spi_reset_pattern.sv */
// Detects the two serial reset patterns on the synchronised serial data line.
// Assumes edge pulses and data come from synchronisers on the same master clock.
`timescale 1ns/10ps
module spi_reset_pattern
  import pwr_reset_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_sclk_fall,
  input wire logic i_sdi,
  input wire logic i_cs_n,
  input wire logic i_cs_rise,
  input wire logic i_four_wire,
  output logic o_pattern_reset
);

  logic [10:0] ones_cnt;
  logic counting;

  // In 3-wire mode chip select is tied low, so it never gates the count.
  assign counting = !i_four_wire || !i_cs_n;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ones_cnt <= 11'h000;
    end else if (i_ce) begin
      if (i_cs_rise && i_four_wire) begin
        ones_cnt <= 11'h000;
      end else if (i_sclk_fall && counting) begin
        if (!i_sdi) begin
          ones_cnt <= 11'h000;
        end else if (ones_cnt != PATTERN_ONES_CS_END) begin
          // Saturates so an arbitrarily long run of ones stays a valid pattern.
          ones_cnt <= ones_cnt + 11'h001;
        end
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pattern_reset <= 1'b0;
    end else if (i_ce) begin
      o_pattern_reset <= (i_sclk_fall && counting && !i_sdi &&
                          ones_cnt >= PATTERN_ONES_ZERO_END) ||
                         (i_cs_rise && i_four_wire &&
                          ones_cnt >= PATTERN_ONES_CS_END);
    end
  end

  property p_pattern_zero;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && i_sclk_fall && counting && !i_sdi && ones_cnt >= PATTERN_ONES_ZERO_END)
      |=> o_pattern_reset;
  endproperty
  a_pattern_zero: assert property (p_pattern_zero) else $error("zero-ended pattern missed");

  property p_pattern_cs;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && i_cs_rise && (!i_four_wire || ones_cnt < PATTERN_ONES_CS_END) &&
       !(i_sclk_fall && counting && !i_sdi)) |=> !o_pattern_reset;
  endproperty
  a_pattern_cs: assert property (p_pattern_cs) else $error("spurious chip-select pattern");

endmodule // spi_reset_pattern

/* hdl/adc_power_mode_reset_ctrl.sv */
// Power-state, reset source and conversion-gating control of the converter core.
// Assumes supply monitors, reset pin, start pin and serial pins are asynchronous, while the
// control-register write strobe and configuration bits come from logic on i_mclk.
`timescale 1ns/10ps

// Notes on behaviour
// - A low or cycled digital I/O supply fully resets the device.
// - Analog supply loss never resets; it only raises the low-voltage flag.
// - Data-ready goes high once the serial side is ready after reset.
// - Start high at release begins converting at once, pulsing data-ready each result.
// - Power-on flag sets on reset and clears only on a host write of one.
// - Analog low-voltage flag sets on any analog monitor low; host write-one clears.
// - A low I/O supply also sets the analog low-voltage flag.
// - Common-mode output drives only while its configuration enable is set.
// - Speed mode selects 25.6 MHz or 3.2 MHz converter clock.
// - Idle stop disables only the filter; sampling continues.
// - Standby stop halts signal and reference sampling until conversions restart.
// - Leaving standby adds 24 cycles to the first result's latency.
// - Power-down turns sections off, keeps serial access; clearing or reset exits.
// - Every reset restarts control, filter and serial side and defaults registers.
// - Reset pin is active low; driving low then high resets.
// - Only the key value written to control resets the device.
// - In 4-wire mode the key reset acts when chip select rises.
// - In 3-wire mode the key reset acts on the write's last falling clock.
// - A zero after at least 1023 ones resets on that falling edge.
// - In 4-wire mode 1024 ones then chip select high resets.
module adc_power_mode_reset_ctrl
  import pwr_reset_pkg::*;
(
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_ce,
  input wire logic i_io_supply_ok,
  input wire logic [3:0] i_analog_supply_ok,
  input wire logic i_reset_pin_n,
  input wire logic i_start,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_sdi,
  input wire logic i_spi_four_wire,
  input wire logic i_ctrl_wr,
  input wire logic [7:0] i_ctrl_wr_data,
  input wire logic i_por_flag_clr,
  input wire logic i_analog_low_voltage_flag_clr,
  input wire logic i_common_mode_enable,
  input wire logic i_speed_high,
  input wire logic i_standby_select,
  input wire logic i_power_down_bit,
  output logic o_data_ready_n,
  output logic o_regs_default,
  output logic o_serial_ready,
  output logic o_por_flag,
  output logic o_analog_low_voltage_flag,
  output logic o_common_mode_out_en,
  output logic [15:0] o_required_mclk_khz,
  output logic o_filter_active,
  output logic o_sampling_active,
  output logic o_analog_power_on,
  output logic o_digital_power_on
);

  logic [SYNC_WIDTH-1:0] sync_ff1;
  logic [SYNC_WIDTH-1:0] sync_ff2;
  logic start_s;
  logic reset_pin_s;
  logic io_ok_s;
  logic sdi_s;
  logic cs_s;
  logic sclk_s;
  logic [3:0] analog_ok_s;
  logic sclk_prev;
  logic cs_prev;
  logic sclk_fall;
  logic cs_rise;
  logic pattern_reset;
  logic key_write;
  logic key_pending;
  logic soft_reset;
  logic dev_reset_req;
  logic analog_low;
  ctrl_state_t state;
  ctrl_state_t next_state;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic [7:0] data_ready_n_cnt;
  logic conv_done;

  // Every asynchronous input passes two flip-flops; only the second stage is read.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
      logic raw;
      if (gi == SYNC_START) begin : g_start
        assign raw = i_start;
      end else if (gi == SYNC_RESET_PIN) begin : g_rst
        assign raw = i_reset_pin_n;
      end else if (gi == SYNC_IO_OK) begin : g_io
        assign raw = i_io_supply_ok;
      end else if (gi == SYNC_SDI) begin : g_sdi
        assign raw = i_sdi;
      end else if (gi == SYNC_CS) begin : g_cs
        assign raw = i_cs_n;
      end else if (gi == SYNC_SCLK) begin : g_sclk
        assign raw = i_sclk;
      end else begin : g_analog
        assign raw = i_analog_supply_ok[gi-SYNC_ANALOG];
      end
      always_ff @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
          sync_ff1[gi] <= SYNC_RESET_VAL[gi];
          sync_ff2[gi] <= SYNC_RESET_VAL[gi];
        end else if (i_ce) begin
          sync_ff1[gi] <= raw;
          sync_ff2[gi] <= sync_ff1[gi];
        end
      end
    end
  endgenerate

  assign start_s = sync_ff2[SYNC_START];
  assign reset_pin_s = sync_ff2[SYNC_RESET_PIN];
  assign io_ok_s = sync_ff2[SYNC_IO_OK];
  assign sdi_s = sync_ff2[SYNC_SDI];
  assign cs_s = sync_ff2[SYNC_CS];
  assign sclk_s = sync_ff2[SYNC_SCLK];
  assign analog_ok_s = sync_ff2[SYNC_ANALOG+3:SYNC_ANALOG];

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sclk_prev <= 1'b0;
      cs_prev <= 1'b1;
    end else if (i_ce) begin
      sclk_prev <= sclk_s;
      cs_prev <= cs_s;
    end
  end

  assign sclk_fall = sclk_prev && !sclk_s;
  assign cs_rise = !cs_prev && cs_s;

  spi_reset_pattern u_pattern (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_ce(i_ce),
    .i_sclk_fall(sclk_fall),
    .i_sdi(sdi_s),
    .i_cs_n(cs_s),
    .i_cs_rise(cs_rise),
    .i_four_wire(i_spi_four_wire),
    .o_pattern_reset(pattern_reset)
  );

  // The write strobe marks the last falling clock of the data byte.
  assign key_write = i_ctrl_wr && (i_ctrl_wr_data == CTRL_RESET_KEY);

  // In 4-wire mode the key is held until the frame closes, so the reset cannot cut
  // the host's frame in half.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      key_pending <= 1'b0;
    end else if (i_ce) begin
      if (state == ST_RESET || cs_rise) begin
        key_pending <= 1'b0;
      end else if (key_write && i_spi_four_wire) begin
        key_pending <= 1'b1;
      end
    end
  end

  assign soft_reset = (key_write && !i_spi_four_wire) ||
                      (key_pending && cs_rise) ||
                      pattern_reset;
  assign dev_reset_req = !io_ok_s || !reset_pin_s || soft_reset;
  assign analog_low = (analog_ok_s != 4'hF) || !io_ok_s;

  assign conv_done = (state == ST_SETTLE || state == ST_CONVERT) && (cnt == 8'h00);

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    unique case (state)
      ST_RESET: begin
        next_cnt = SERIAL_READY_COUNT - 8'h01;
        next_state = ST_WAIT_READY;
      end
      ST_WAIT_READY: begin
        next_cnt = cnt - 8'h01;
        if (cnt == 8'h00) begin
          next_state = ST_STOPPED;
        end
      end
      ST_STOPPED: begin
        if (i_power_down_bit) begin
          next_state = ST_POWER_DOWN;
        end else if (start_s) begin
          next_state = ST_SETTLE;
          next_cnt = i_standby_select ? LATENCY_CYCLES + STANDBY_EXTRA_CYCLES - 8'h01
                                      : LATENCY_CYCLES - 8'h01;
        end
      end
      ST_SETTLE, ST_CONVERT: begin
        next_cnt = cnt - 8'h01;
        if (i_power_down_bit) begin
          next_state = ST_POWER_DOWN;
        end else if (conv_done) begin
          // The conversion in progress finishes before a stop takes hold; power-down or a reset cuts it short.
          next_state = start_s ? ST_CONVERT : ST_STOPPED;
          next_cnt = CONV_PERIOD_CYCLES - 8'h01;
        end
      end
      ST_POWER_DOWN: begin
        if (!i_power_down_bit) begin
          next_state = ST_STOPPED;
        end
      end
      default: begin
        next_state = ST_RESET;
      end
    endcase
    if (dev_reset_req) begin
      next_state = ST_RESET;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= ST_RESET;
      cnt <= 8'h00;
    end else if (i_ce) begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Data-ready stays low through reset, rises when the serial side is ready and then
  // drops for a short pulse at each finished conversion.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_data_ready_n <= 1'b0;
      data_ready_n_cnt <= 8'h00;
    end else if (i_ce) begin
      if (dev_reset_req || state == ST_RESET || state == ST_WAIT_READY) begin
        o_data_ready_n <= !dev_reset_req && (state == ST_WAIT_READY) &&
                          (cnt == 8'h00);
        data_ready_n_cnt <= 8'h00;
      end else if (conv_done && !i_power_down_bit) begin
        o_data_ready_n <= 1'b0;
        data_ready_n_cnt <= DATA_READY_N_LOW_CYCLES - 8'h01;
      end else if (data_ready_n_cnt != 8'h00) begin
        data_ready_n_cnt <= data_ready_n_cnt - 8'h01;
      end else begin
        o_data_ready_n <= 1'b1;
      end
    end
  end

  // Set beats clear so an event landing on the host's clear is never lost.
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_por_flag <= POR_FLAG_RESET;
      o_analog_low_voltage_flag <= ANALOG_LOW_VOLTAGE_FLAG_RESET;
    end else if (i_ce) begin
      if (dev_reset_req) begin
        o_por_flag <= 1'b1;
      end else if (i_por_flag_clr) begin
        o_por_flag <= 1'b0;
      end
      if (analog_low) begin
        o_analog_low_voltage_flag <= 1'b1;
      end else if (i_analog_low_voltage_flag_clr) begin
        o_analog_low_voltage_flag <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_regs_default <= 1'b1;
      o_serial_ready <= 1'b0;
      o_common_mode_out_en <= 1'b0;
      o_required_mclk_khz <= LS_MCLK_KHZ;
      o_filter_active <= 1'b0;
      o_sampling_active <= 1'b0;
      o_analog_power_on <= 1'b0;
      o_digital_power_on <= 1'b0;
    end else if (i_ce) begin
      o_regs_default <= (state == ST_RESET);
      // Rises on the same edge as data-ready, so data-ready never leads the serial side.
      o_serial_ready <= (state != ST_RESET) && (state != ST_WAIT_READY || cnt == 8'h00);
      o_common_mode_out_en <= i_common_mode_enable && (state != ST_RESET) &&
                              (state != ST_POWER_DOWN);
      o_required_mclk_khz <= i_speed_high ? HS_MCLK_KHZ : LS_MCLK_KHZ;
      o_filter_active <= (state == ST_SETTLE) || (state == ST_CONVERT);
      o_sampling_active <= (state == ST_SETTLE) || (state == ST_CONVERT) ||
                           (state == ST_STOPPED && !i_standby_select);
      o_analog_power_on <= (state != ST_POWER_DOWN) && (state != ST_RESET);
      o_digital_power_on <= (state != ST_POWER_DOWN);
    end
  end

  property p_por_set;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && dev_reset_req) |=> o_por_flag && state == ST_RESET;
  endproperty
  a_por_set: assert property (p_por_set) else $error("reset did not set power-on flag");

  property p_alv_io;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && !io_ok_s) |=> o_analog_low_voltage_flag;
  endproperty
  a_alv_io: assert property (p_alv_io) else $error("io supply low missed analog_low_voltage_flag");

  property p_alv_hold;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && o_analog_low_voltage_flag && !i_analog_low_voltage_flag_clr) |=> o_analog_low_voltage_flag;
  endproperty
  a_alv_hold: assert property (p_alv_hold) else $error("analog_low_voltage_flag lost without clear");

  property p_common_mode;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && !i_common_mode_enable) |=> !o_common_mode_out_en;
  endproperty
  a_common_mode: assert property (p_common_mode) else $error("common mode driven while off");

  property p_mclk_req;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && i_speed_high) |=> o_required_mclk_khz == HS_MCLK_KHZ;
  endproperty
  a_mclk_req: assert property (p_mclk_req) else $error("wrong clock for speed mode");

  property p_standby;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && state == ST_STOPPED && i_standby_select) |=> !o_sampling_active && !o_filter_active;
  endproperty
  a_standby: assert property (p_standby) else $error("sampling ran in standby");

  property p_idle;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && state == ST_STOPPED && !i_standby_select) |=> o_sampling_active && !o_filter_active;
  endproperty
  a_idle: assert property (p_idle) else $error("idle mode state wrong");

  property p_standby_latency;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && state == ST_STOPPED && next_state == ST_SETTLE && i_standby_select)
      |=> cnt == LATENCY_CYCLES + STANDBY_EXTRA_CYCLES - 8'h01;
  endproperty
  a_standby_latency: assert property (p_standby_latency) else $error("standby latency wrong");

  property p_power_down;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && state == ST_POWER_DOWN) |=> !o_analog_power_on && !o_digital_power_on &&
                                          o_serial_ready;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power-down outputs wrong");

  property p_key_3wire;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (i_ce && key_write && !i_spi_four_wire) |=> state == ST_RESET ##1 o_regs_default;
  endproperty
  a_key_3wire: assert property (p_key_3wire) else $error("3-wire key reset missed");

  property p_data_ready_n_ready;
    @(posedge i_mclk) disable iff (!i_arst_n)
      (state == ST_RESET) |-> !o_data_ready_n;
  endproperty
  a_data_ready_n_ready: assert property (p_data_ready_n_ready) else $error("data ready high during reset");

endmodule // adc_power_mode_reset_ctrl

/* testbench/spi_host_model.sv */
// Behavioural serial host that drives clock, chip select and data towards the controller.
// Assumes the bench calls one task at a time; the serial clock idles low between frames.
`timescale 1ns/10ps
module spi_host_model #(
  parameter int HALF_NS = 80
) (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_sdi
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_sdi = 1'b0;
  end

  // The odd start offset keeps serial edges away from the master clock edges.
  task automatic begin_frame();
    #7;
    o_cs_n = 1'b0;
    #HALF_NS;
  endtask

  task automatic shift_bit(input logic b);
    o_sdi = b;
    o_sclk = 1'b1;
    #HALF_NS;
    o_sclk = 1'b0;
    #HALF_NS;
  endtask

  // At frame end the data line is driven to the inverse of its last bit.
  task automatic end_frame();
    o_cs_n = 1'b1;
    o_sdi = ~o_sdi;
    #HALF_NS;
  endtask

  // Pattern resets need no frame sync, which makes them the safe choice in 3-wire mode.
  task automatic send_pattern(input int n_ones, input logic zero_end);
    begin_frame();
    for (int k = 0; k < n_ones; k++) begin
      shift_bit(1'b1);
    end
    if (zero_end) begin
      shift_bit(1'b0);
    end
  endtask
endmodule  // spi_host_model

/* testbench/adc_power_mode_reset_ctrl_tb.sv */
// Self-checking bench for the power-state and reset controller.
// Assumes a 50 MHz master clock and a serial host model running its own 160 ns clock.
`timescale 1ns/10ps
module adc_power_mode_reset_ctrl_tb;
  import pwr_reset_pkg::*;
  logic i_mclk = 1'b0, i_arst_n = 1'b0, i_ce = 1'b1, i_io_supply_ok = 1'b1;
  logic [3:0] i_analog_supply_ok = 4'hF;
  logic i_reset_pin_n = 1'b1, i_start = 1'b0, i_spi_four_wire = 1'b0, i_ctrl_wr = 1'b0;
  logic [7:0] i_ctrl_wr_data = 8'h00;
  logic i_por_flag_clr = 1'b0, i_analog_low_voltage_flag_clr = 1'b0, i_common_mode_enable = 1'b0;
  logic i_speed_high = 1'b0, i_standby_select = 1'b0, i_power_down_bit = 1'b0;
  logic o_data_ready_n, o_regs_default, o_serial_ready, o_por_flag;
  logic o_analog_low_voltage_flag, o_common_mode_out_en, o_filter_active;
  logic o_sampling_active, o_analog_power_on, o_digital_power_on;
  logic [15:0] o_required_mclk_khz;
  wire sclk, cs_n, sdi;
  int n_errors = 0;
  int comparisons = 0;
  int lat_idle, lat_stby;
  logic reset_seen = 1'b0;
  logic seen_clr = 1'b0;

  spi_host_model host (.o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

  adc_power_mode_reset_ctrl DUT (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_ce(i_ce), .i_io_supply_ok(i_io_supply_ok),
    .i_analog_supply_ok(i_analog_supply_ok), .i_reset_pin_n(i_reset_pin_n),
    .i_start(i_start), .i_sclk(sclk), .i_cs_n(cs_n), .i_sdi(sdi),
    .i_spi_four_wire(i_spi_four_wire), .i_ctrl_wr(i_ctrl_wr),
    .i_ctrl_wr_data(i_ctrl_wr_data), .i_por_flag_clr(i_por_flag_clr),
    .i_analog_low_voltage_flag_clr(i_analog_low_voltage_flag_clr), .i_common_mode_enable(i_common_mode_enable),
    .i_speed_high(i_speed_high), .i_standby_select(i_standby_select),
    .i_power_down_bit(i_power_down_bit), .o_data_ready_n(o_data_ready_n),
    .o_regs_default(o_regs_default), .o_serial_ready(o_serial_ready),
    .o_por_flag(o_por_flag), .o_analog_low_voltage_flag(o_analog_low_voltage_flag),
    .o_common_mode_out_en(o_common_mode_out_en), .o_required_mclk_khz(o_required_mclk_khz),
    .o_filter_active(o_filter_active), .o_sampling_active(o_sampling_active),
    .o_analog_power_on(o_analog_power_on), .o_digital_power_on(o_digital_power_on));

  initial begin
    forever #10 i_mclk = ~i_mclk;
  end

  // A soft reset raises the default request for one cycle only, so it is latched here.
  always @(posedge i_mclk) begin
    if (o_regs_default === 1'b1) begin
      reset_seen <= 1'b1;
    end else if (seen_clr) begin
      reset_seen <= 1'b0;
    end
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic timeout(input string what);
    n_errors++;
    $display("MISMATCH %s expected completion seen timeout", what);
    conclude();
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask

  task automatic wait_ready();
    int k = 0;
    while (!(o_data_ready_n === 1'b1 && o_regs_default === 1'b0) && k < 60) begin
      cyc(1);
      k++;
    end
    if (k >= 60) timeout("ready");
    check("serial_ready", o_serial_ready, 1'b1);
    seen_clr <= 1'b1;
    cyc(1);
    seen_clr <= 1'b0;
  endtask

  // Waits a bounded time for a reset; when one is seen, also waits for readiness.
  task automatic expect_reset(input logic exp, input string what);
    logic seen = 1'b0;
    for (int k = 0; k < 20 && !seen; k++) begin
      cyc(1);
      seen = (reset_seen === 1'b1);
    end
    check(what, seen, exp);
    if (seen) begin
      check({what, " por_flag"}, o_por_flag, 1'b1);
      wait_ready();
      pulse_clr(1'b1, 1'b0);
    end
  endtask

  task automatic pulse_clr(input logic por, input logic alv);
    @(posedge i_mclk);
    i_por_flag_clr <= por;
    i_analog_low_voltage_flag_clr <= alv;
    @(posedge i_mclk);
    i_por_flag_clr <= 1'b0;
    i_analog_low_voltage_flag_clr <= 1'b0;
    cyc(2);
  endtask

  task automatic wr_ctrl(input logic [7:0] d);
    @(posedge i_mclk);
    i_ctrl_wr <= 1'b1;
    i_ctrl_wr_data <= d;
    @(posedge i_mclk);
    i_ctrl_wr <= 1'b0;
  endtask

  task automatic test_power_on();
    cyc(1);
    check("por_flag in reset", o_por_flag, 1'b1);
    check("analog_low_voltage_flag in reset", o_analog_low_voltage_flag, 1'b1);
    check("regs_default in reset", o_regs_default, 1'b1);
    check("mclk_khz in reset", o_required_mclk_khz, 16'h0C80);
    @(posedge i_mclk);
    i_arst_n <= 1'b1;
    wait_ready();
    check("por_flag held", o_por_flag, 1'b1);
    pulse_clr(1'b1, 1'b1);
    check("por_flag cleared", o_por_flag, 1'b0);
    check("analog_low_voltage_flag cleared", o_analog_low_voltage_flag, 1'b0);
    $display("test power_on done");
  endtask

  task automatic test_config();
    @(posedge i_mclk);
    i_common_mode_enable <= 1'b1;
    i_speed_high <= 1'b1;
    cyc(4);
    check("cm_en on", o_common_mode_out_en, 1'b1);
    check("mclk_khz high", o_required_mclk_khz, 16'h6400);
    @(posedge i_mclk);
    i_common_mode_enable <= 1'b0;
    i_speed_high <= 1'b0;
    i_power_down_bit <= 1'b1;
    cyc(5);
    check("cm_en off", o_common_mode_out_en, 1'b0);
    check("mclk_khz low", o_required_mclk_khz, 16'h0C80);
    check("analog power in pd", o_analog_power_on, 1'b0);
    check("digital power in pd", o_digital_power_on, 1'b0);
    check("serial in pd", o_serial_ready, 1'b1);
    @(posedge i_mclk);
    i_power_down_bit <= 1'b0;
    cyc(5);
    check("analog power after pd", o_analog_power_on, 1'b1);
    check("digital power after pd", o_digital_power_on, 1'b1);
    $display("test config done");
  endtask

  // Counts cycles from start to the first result, then stops and lets the last one finish.
  task automatic measure(output int n);
    n = 0;
    @(posedge i_mclk);
    i_start <= 1'b1;
    while (o_data_ready_n !== 1'b0 && n < 300) begin
      cyc(1);
      n++;
    end
    if (n >= 300) timeout("first result");
    check("filter converting", o_filter_active, 1'b1);
    check("sampling converting", o_sampling_active, 1'b1);
    @(posedge i_mclk);
    i_start <= 1'b0;
    cyc(100);
  endtask

  task automatic test_standby();
    measure(lat_idle);
    check("filter idle", o_filter_active, 1'b0);
    check("sampling idle", o_sampling_active, 1'b1);
    @(posedge i_mclk);
    i_standby_select <= 1'b1;
    cyc(4);
    check("sampling standby", o_sampling_active, 1'b0);
    measure(lat_stby);
    check("sampling standby again", o_sampling_active, 1'b0);
    check("standby extra latency", 16'(lat_stby - lat_idle), 16'h0018);
    @(posedge i_mclk);
    i_standby_select <= 1'b0;
    $display("test standby done");
  endtask

  task automatic test_supplies();
    for (int b = 0; b < 4; b++) begin
      @(posedge i_mclk);
      i_analog_supply_ok <= ~(4'h1 << b);
      cyc(6);
      check("analog_low_voltage_flag set", o_analog_low_voltage_flag, 1'b1);
      check("no reset on analog", o_regs_default, 1'b0);
      @(posedge i_mclk);
      i_analog_supply_ok <= 4'hF;
      cyc(6);
      check("analog_low_voltage_flag kept", o_analog_low_voltage_flag, 1'b1);
      check("por_flag untouched", o_por_flag, 1'b0);
      pulse_clr(1'b0, 1'b1);
      check("analog_low_voltage_flag clr", o_analog_low_voltage_flag, 1'b0);
    end
    @(posedge i_mclk);
    i_io_supply_ok <= 1'b0;
    cyc(4);
    @(posedge i_mclk);
    i_io_supply_ok <= 1'b1;
    expect_reset(1'b1, "io supply reset");
    check("analog_low_voltage_flag on io low", o_analog_low_voltage_flag, 1'b1);
    pulse_clr(1'b1, 1'b1);
    $display("test supplies done");
  endtask

  task automatic test_pin_start();
    int n = 0;
    @(posedge i_mclk);
    i_start <= 1'b1;
    i_reset_pin_n <= 1'b0;
    cyc(3);
    @(posedge i_mclk);
    i_reset_pin_n <= 1'b1;
    expect_reset(1'b1, "pin reset");
    while (o_data_ready_n !== 1'b0 && n < 200) begin
      cyc(1);
      n++;
    end
    check("conversion at release", 16'(n < 200), 16'h0001);
    @(posedge i_mclk);
    i_start <= 1'b0;
    cyc(100);
    $display("test pin_start done");
  endtask

  task automatic test_key();
    wr_ctrl(8'h59);
    expect_reset(1'b0, "other value");
    wr_ctrl(8'h58);
    expect_reset(1'b1, "key 3-wire");
    @(posedge i_mclk);
    i_spi_four_wire <= 1'b1;
    host.begin_frame();
    wr_ctrl(8'h58);
    expect_reset(1'b0, "key before cs high");
    host.end_frame();
    expect_reset(1'b1, "key at cs high");
    $display("test key done");
  endtask

  task automatic test_patterns();
    @(posedge i_mclk);
    i_spi_four_wire <= 1'b0;
    host.send_pattern(1023, 1'b1);
    expect_reset(1'b1, "pattern ones zero");
    host.end_frame();
    @(posedge i_mclk);
    i_spi_four_wire <= 1'b1;
    host.send_pattern(1022, 1'b1);
    host.end_frame();
    expect_reset(1'b0, "pattern short");
    host.send_pattern(1024, 1'b0);
    host.end_frame();
    expect_reset(1'b1, "pattern cs high");
    $display("test patterns done");
  endtask

  initial begin
    test_power_on();
    test_config();
    test_standby();
    test_supplies();
    test_pin_start();
    test_key();
    test_patterns();
    conclude();
  end
endmodule  // adc_power_mode_reset_ctrl_tb
